// ### include/fpo_defines.vh
// Functional notes
// - Several selectable panel data formats supported.
// - Dual scan splits pins into upper/lower groups.
// - Two-pixel panels: upper nibbles of both pixels interleaved per colour.
// - Optional data transfer on both shift edges.
// - Three lanes, ten bits per link clock.
// - One symbol per lane per link cycle.
// - Every data byte encoded to ten bits.
// - Four reserved control symbols never encode data.
// - Control levels change only during blanking.
// - Reserved symbol marks blanking, encodes two controls.
// - Three bytes per link cycle, one per lane.
// - Parallel data held low while link enabled.
// - Shift clock qualifies the parallel panel data.
`ifndef FPO_DEFINES_VH
`define FPO_DEFINES_VH

`define FPO_PIX_W 24
`define FPO_CTL_W 6
`define FPO_WORD_W 31
`define FPO_CTL_LSB 24
`define FPO_BLANK_BIT 30
`define FPO_FIFO_DEPTH 16
`define FPO_FIFO_AW 4
`define FPO_SYM_W 10
`define FPO_DISP_W 5
`define FPO_COLL_W 192

// Panel format selector codes.
`define FPO_FMT_MONO_SS8 3'h0
`define FPO_FMT_MONO_DD8 3'h1
`define FPO_FMT_TFT16 3'h2
`define FPO_FMT_TFT24 3'h3
`define FPO_FMT_TWO_PIXEL 3'h4
`define FPO_FMT_DUAL_COLOUR 3'h5

// Pixels collected per shift clock for each format.
`define FPO_PPC_ONE 4'h1
`define FPO_PPC_TWO 4'h2
`define FPO_PPC_EIGHT 4'h8

// Reserved link symbols, indexed by the two control levels of a lane.
`define FPO_CTRL_SYM_00 10'h354
`define FPO_CTRL_SYM_01 10'h0ab
`define FPO_CTRL_SYM_10 10'h154
`define FPO_CTRL_SYM_11 10'h2ab

`endif

// ### rtl/fpo_fifo.v
`timescale 1ns/1ps
`include "fpo_defines.vh"

module fpo_fifo #(
   parameter W = `FPO_WORD_W,
   parameter D = `FPO_FIFO_DEPTH,
   parameter AW = `FPO_FIFO_AW
) (
   input wire ref_clk_in,
   input wire nrst_in,
   input wire in_valid_in,
   output wire in_ready_out,
   input wire [W-1:0] in_data_in,
   output wire out_valid_out,
   input wire out_ready_in,
   output wire [W-1:0] out_data_out
);

   reg [W-1:0] mem_q [0:D-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0] cnt_q;
   reg [AW:0] cnt_d;
   reg in_ready_q;
   reg out_valid_q;
   reg [W-1:0] out_data_q;
   wire push;
   wire load;

   assign push = in_valid_in && in_ready_q;
   assign load = (cnt_q != {(AW+1){1'b0}}) && (!out_valid_q || out_ready_in);
   assign in_ready_out = in_ready_q;
   assign out_valid_out = out_valid_q;
   assign out_data_out = out_data_q;

   always @* begin
      cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
   end

   // Ready is registered from the next count, so a full memory stalls the writer at once.
   always @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         wp_q <= {AW{1'b0}};
         rp_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         in_ready_q <= 1'b0;
         out_valid_q <= 1'b0;
         out_data_q <= {W{1'b0}};
      end else begin
         cnt_q <= cnt_d;
         in_ready_q <= (cnt_d < D);
         if (push) begin
            wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (load) begin
            rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
            out_data_q <= mem_q[rp_q];
            out_valid_q <= 1'b1;
         end else if (out_ready_in) begin
            out_valid_q <= 1'b0;
         end
      end
   end

   always @(posedge ref_clk_in) begin
      if (push) begin
         mem_q[wp_q] <= in_data_in;
      end
   end

endmodule // fpo_fifo

// ### rtl/fpo_top.v
`timescale 1ns/1ps
`include "fpo_defines.vh"

module fpo_top (
   input wire ref_clk_in,
   input wire nrst_in,
   input wire [23:0] pix_data_in,
   input wire [5:0] pix_ctl_in,
   input wire pix_blank_in,
   input wire pix_valid_in,
   output wire pix_ready_out,
   input wire [2:0] fmt_sel_in,
   input wire dual_edge_in,
   input wire link_en_in,
   input wire serial_link_clock_in,
   output wire [23:0] panel_data_out,
   output wire panel_shift_clock_out,
   output wire serial_link_clock_out,
   output wire [9:0] serial_lane_0_out,
   output wire [9:0] serial_lane_1_out,
   output wire [9:0] serial_lane_2_out
);

   localparam PH_IDLE = 2'b00;
   localparam PH_EDGE = 2'b01;
   localparam PH_FALL = 2'b10;

   // Pixels that make up one shift clock word for a format.
   function [3:0] fpo_ppc;
      input [2:0] fmt;
      begin
         case (fmt)
            `FPO_FMT_MONO_SS8: fpo_ppc = `FPO_PPC_EIGHT;
            `FPO_FMT_MONO_DD8: fpo_ppc = `FPO_PPC_EIGHT;
            `FPO_FMT_TWO_PIXEL: fpo_ppc = `FPO_PPC_TWO;
            `FPO_FMT_DUAL_COLOUR: fpo_ppc = `FPO_PPC_EIGHT;
            default: fpo_ppc = `FPO_PPC_ONE;
         endcase
      end
   endfunction

   // Places collected pixels on the panel pins. Pixel k sits at bits 24k+23..24k.
   // Dual scan streams alternate upper and lower pixels; mono takes the green MSB.
   function [23:0] fpo_map;
      input [2:0] fmt;
      input [191:0] c;
      integer k;
      begin
         fpo_map = 24'h000000;
         case (fmt)
            `FPO_FMT_MONO_SS8: begin
               for (k = 0; k < 8; k = k + 1) begin
                  fpo_map[k] = c[24*k+15];
               end
            end
            `FPO_FMT_MONO_DD8: begin
               for (k = 0; k < 4; k = k + 1) begin
                  fpo_map[k] = c[48*k+15];
                  fpo_map[k+4] = c[48*k+39];
               end
            end
            `FPO_FMT_TFT16: begin
               fpo_map[15:0] = {c[23:19], c[15:10], c[7:3]};
            end
            `FPO_FMT_TFT24: begin
               fpo_map = c[23:0];
            end
            `FPO_FMT_TWO_PIXEL: begin
               fpo_map = {c[47:44], c[23:20], c[39:36], c[15:12], c[31:28], c[7:4]};
            end
            `FPO_FMT_DUAL_COLOUR: begin
               for (k = 0; k < 8; k = k + 1) begin
                  fpo_map[3*k] = c[24*k+23];
                  fpo_map[3*k+1] = c[24*k+15];
                  fpo_map[3*k+2] = c[24*k+7];
               end
            end
            default: begin
               fpo_map = c[23:0];
            end
         endcase
      end
   endfunction

   // Transition-minimised, DC-balanced byte coding. Its output set never
   // meets the four reserved control symbols. Returns {disparity, symbol}.
   function [14:0] fpo_enc;
      input [7:0] d;
      input [4:0] cnt;
      reg [8:0] m;
      reg [3:0] n1d;
      reg [3:0] n1m;
      reg [4:0] diff;
      reg xn;
      reg [9:0] q;
      reg [4:0] nc;
      integer i;
      begin
         n1d = 4'h0;
         n1m = 4'h0;
         for (i = 0; i < 8; i = i + 1) begin
            n1d = n1d + {3'h0, d[i]};
         end
         xn = (n1d > 4'h4) || ((n1d == 4'h4) && !d[0]);
         m[0] = d[0];
         for (i = 1; i < 8; i = i + 1) begin
            m[i] = xn ? ~(m[i-1] ^ d[i]) : (m[i-1] ^ d[i]);
         end
         m[8] = ~xn;
         for (i = 0; i < 8; i = i + 1) begin
            n1m = n1m + {3'h0, m[i]};
         end
         diff = {n1m, 1'b0} - 5'h08;
         if ((cnt == 5'h00) || (n1m == 4'h4)) begin
            q = {~m[8], m[8], (m[8] ? m[7:0] : ~m[7:0])};
            nc = m[8] ? (cnt + diff) : (cnt - diff);
         end else if ((!cnt[4] && (n1m > 4'h4)) || (cnt[4] && (n1m < 4'h4))) begin
            q = {1'b1, m[8], ~m[7:0]};
            nc = cnt + {3'h0, m[8], 1'b0} - diff;
         end else begin
            q = {1'b0, m[8], m[7:0]};
            nc = cnt - {3'h0, ~m[8], 1'b0} + diff;
         end
         fpo_enc = {nc, q};
      end
   endfunction

   // Reserved symbol chosen by the two control levels of a lane.
   function [9:0] fpo_ctrl;
      input [1:0] lv;
      begin
         case (lv)
            2'b00: fpo_ctrl = `FPO_CTRL_SYM_00;
            2'b01: fpo_ctrl = `FPO_CTRL_SYM_01;
            2'b10: fpo_ctrl = `FPO_CTRL_SYM_10;
            default: fpo_ctrl = `FPO_CTRL_SYM_11;
         endcase
      end
   endfunction

   wire fifo_valid;
   wire fifo_ready;
   wire [30:0] fifo_word;
   wire pop;
   wire word_blank;
   wire [3:0] ppc;
   wire coll_take;
   wire lclk_rise;

   reg lclk_s1_q;
   reg lclk_s2_q;
   reg lclk_s3_q;
   reg [191:0] coll_q;
   reg [3:0] coll_cnt_q;
   reg [1:0] phase_q;
   reg [23:0] panel_q;
   reg shift_clk_q;
   reg link_clk_q;
   reg [5:0] ctl_q;

   fpo_fifo #(
      .W(`FPO_WORD_W),
      .D(`FPO_FIFO_DEPTH),
      .AW(`FPO_FIFO_AW)
   ) u_fifo (
      .ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .in_valid_in(pix_valid_in),
      .in_ready_out(pix_ready_out),
      .in_data_in({pix_blank_in, pix_ctl_in, pix_data_in}),
      .out_valid_out(fifo_valid),
      .out_ready_in(fifo_ready),
      .out_data_out(fifo_word)
   );

   assign ppc = fpo_ppc(fmt_sel_in);
   assign coll_take = !link_en_in && (coll_cnt_q < ppc);
   assign lclk_rise = lclk_s2_q && !lclk_s3_q;
   // The link drains at most one word per link clock, none when the FIFO is empty; the panel drains as the collector has room.
   assign fifo_ready = link_en_in ? lclk_rise : coll_take;
   assign pop = fifo_valid && fifo_ready;
   assign word_blank = fifo_word[`FPO_BLANK_BIT];

   // The first stage is read only by the second.
   always @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         lclk_s1_q <= 1'b0;
         lclk_s2_q <= 1'b0;
         lclk_s3_q <= 1'b0;
      end else begin
         lclk_s1_q <= serial_link_clock_in;
         lclk_s2_q <= lclk_s1_q;
         lclk_s3_q <= lclk_s2_q;
      end
   end

   // Parallel panel path: gather pixels, then present one word per shift clock.
   always @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         coll_q <= {`FPO_COLL_W{1'b0}};
         coll_cnt_q <= 4'h0;
         phase_q <= PH_IDLE;
         panel_q <= 24'h000000;
         shift_clk_q <= 1'b0;
      end else if (link_en_in) begin
         coll_cnt_q <= 4'h0;
         phase_q <= PH_IDLE;
         panel_q <= 24'h000000;
         shift_clk_q <= 1'b0;
      end else begin
         // Blanking words carry no pixels and are dropped here.
         if (pop && !word_blank) begin
            coll_q[coll_cnt_q*24 +: 24] <= fifo_word[23:0];
            coll_cnt_q <= coll_cnt_q + 4'h1;
         end
         case (phase_q)
            PH_IDLE: begin
               if (coll_cnt_q >= ppc) begin
                  panel_q <= fpo_map(fmt_sel_in, coll_q);
                  coll_cnt_q <= 4'h0;
                  phase_q <= PH_EDGE;
               end
            end
            PH_EDGE: begin
               // Data stood one cycle before this edge, so the panel samples stable pins.
               if (dual_edge_in) begin
                  shift_clk_q <= ~shift_clk_q;
                  phase_q <= PH_IDLE;
               end else begin
                  shift_clk_q <= 1'b1;
                  phase_q <= PH_FALL;
               end
            end
            PH_FALL: begin
               shift_clk_q <= 1'b0;
               phase_q <= PH_IDLE;
            end
            default: begin
               phase_q <= PH_IDLE;
            end
         endcase
      end
   end

   // Control levels are taken only from blanking words, so active video cannot move them.
   always @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         ctl_q <= 6'h00;
         link_clk_q <= 1'b0;
      end else begin
         link_clk_q <= link_en_in && lclk_s2_q;
         if (link_en_in && pop && word_blank) begin
            ctl_q <= fifo_word[29:24];
         end
      end
   end

   genvar l;
   generate
      for (l = 0; l < 3; l = l + 1) begin : g_lane
         wire [14:0] enc;
         wire [1:0] lv;
         reg [9:0] sym_q;
         reg [4:0] disp_q;
         assign enc = fpo_enc(fifo_word[8*l+7:8*l], disp_q);
         // An empty FIFO still sends a symbol, holding the last control levels.
         assign lv = (pop && word_blank) ? fifo_word[`FPO_CTL_LSB+2*l+1:`FPO_CTL_LSB+2*l] : ctl_q[2*l+1:2*l];
         always @(posedge ref_clk_in) begin
            if (!nrst_in) begin
               sym_q <= `FPO_CTRL_SYM_00;
               disp_q <= 5'h00;
            end else if (link_en_in && lclk_rise) begin
               if (pop && !word_blank) begin
                  sym_q <= enc[9:0];
                  disp_q <= enc[14:10];
               end else begin
                  sym_q <= fpo_ctrl(lv);
                  disp_q <= 5'h00;
               end
            end
         end
      end
   endgenerate

   assign panel_data_out = panel_q;
   assign panel_shift_clock_out = shift_clk_q;
   assign serial_link_clock_out = link_clk_q;
   assign serial_lane_0_out = g_lane[0].sym_q;
   assign serial_lane_1_out = g_lane[1].sym_q;
   assign serial_lane_2_out = g_lane[2].sym_q;

endmodule // fpo_top

// ### tb/fpo_top_assertions.sv
`timescale 1ns/1ps
`include "fpo_defines.vh"
module fpo_checker (
   input wire ref_clk_in,
   input wire nrst_in,
   input wire dual_edge_in,
   input wire link_en_in,
   input wire serial_link_clock_in,
   input wire [23:0] panel_data_out,
   input wire panel_shift_clock_out,
   input wire serial_link_clock_out,
   input wire [9:0] serial_lane_0_out,
   input wire [9:0] serial_lane_1_out,
   input wire [9:0] serial_lane_2_out
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!nrst_in);
   function automatic logic rsv(input logic [9:0] s);
      rsv = s == `FPO_CTRL_SYM_00 || s == `FPO_CTRL_SYM_01 || s == `FPO_CTRL_SYM_10 || s == `FPO_CTRL_SYM_11;
   endfunction
   AST_PINS_LOW: assert property (link_en_in && $past(link_en_in) |-> panel_data_out == 24'h0)
      else $error("panel pins driven in link mode");
   AST_LINK_CLK_IDLE: assert property (!link_en_in && !$past(link_en_in) |-> !serial_link_clock_out)
      else $error("link clock forwarded in panel mode");
   AST_CLK_FORWARD: assert property (link_en_in && $rose(serial_link_clock_in) |->
      ##[1:5] ($rose(serial_link_clock_out) || !link_en_in)) else $error("link clock not forwarded");
   AST_LANES_ON_CLK: assert property ($past(nrst_in) && $changed({serial_lane_2_out, serial_lane_1_out,
      serial_lane_0_out}) |-> $rose(serial_link_clock_out)) else $error("symbol changed off link clock");
   AST_SYMBOL_HOLDS: assert property ($rose(serial_link_clock_out) |=>
      $stable({serial_lane_2_out, serial_lane_1_out, serial_lane_0_out}) [*4]) else $error("symbol too short");
   AST_RESERVED_TOGETHER: assert property (rsv(serial_lane_0_out) |->
      rsv(serial_lane_1_out) && rsv(serial_lane_2_out)) else $error("reserved symbol on one lane only");
   AST_SHIFT_PULSE: assert property (!dual_edge_in && $rose(panel_shift_clock_out) |=>
      $fell(panel_shift_clock_out)) else $error("shift pulse not one cycle");
   AST_SHIFT_AFTER_DATA: assert property (!link_en_in && $changed(panel_data_out) |=>
      $changed(panel_shift_clock_out)) else $error("no shift edge after panel data");
   AST_DATA_AT_SHIFT: assert property (!link_en_in && !$past(link_en_in) && $changed(panel_shift_clock_out)
      |-> $stable(panel_data_out)) else $error("panel data moved on shift edge");
endmodule // fpo_checker
bind fpo_top fpo_checker u_chk (.*);

// ### tb/fpo_panel_model.sv
`timescale 1ns/1ps
module fpo_panel_model (
   input wire ref_clk_in,
   input wire dual_in,
   input wire shift_in,
   input wire [23:0] pdata_in,
   input wire lclk_in,
   input wire [29:0] lanes_in,
   output logic [23:0] word_out = 24'h0,
   output logic [29:0] sym_out = 30'h0,
   output logic [15:0] pcnt_out = 16'h0,
   output logic [15:0] lcnt_out = 16'h0
);
   logic sh_q = 1'b0;
   logic lk_q = 1'b0;
   always @(posedge ref_clk_in) begin
      sh_q <= shift_in;
      lk_q <= lclk_in;
      // The panel latches on the rising shift edge, and on the falling one too in dual-edge mode.
      if (shift_in != sh_q && (shift_in || dual_in)) begin
         word_out <= pdata_in;
         pcnt_out <= pcnt_out + 16'h1;
      end
      if (lclk_in && !lk_q) begin
         sym_out <= lanes_in;
         lcnt_out <= lcnt_out + 16'h1;
      end
   end
endmodule // fpo_panel_model

// ### tb/flat_panel_pixel_output_tb.sv
`timescale 1ns/1ps
`include "fpo_defines.vh"
module flat_panel_pixel_output_tb;
   typedef struct packed {logic d; logic [2:0] f; logic [7:0] s; logic [23:0] p0, p1, e;} fpo_row_t;
   // Pixel k of a row is p0 where bit k of s is set, else p1.
   localparam fpo_row_t ROWS [0:8] = '{'{1'b0, 3'h3, 8'h01, 24'h123456, 24'h0, 24'h123456},
      '{1'b0, 3'h2, 8'h01, 24'ha5c396, 24'h0, 24'h00a612}, '{1'b0, 3'h4, 8'h01, 24'habcdef, 24'h123456, 24'h1a3c5e},
      '{1'b0, 3'h0, 8'ha5, 24'h008000, 24'hff7fff, 24'h0000a5}, '{1'b0, 3'h1, 8'h06, 24'h008000, 24'hff7fff, 24'h000012},
      '{1'b0, 3'h5, 8'h03, 24'h800080, 24'h7f7f7f, 24'h00002d}, '{1'b0, 3'h7, 8'h01, 24'h0f0f0f, 24'h0, 24'h0f0f0f},
      '{1'b1, 3'h3, 8'h01, 24'hc0ffee, 24'h0, 24'hc0ffee},
      '{1'b1, 3'h3, 8'h01, 24'h13579b, 24'h0, 24'h13579b}};
   localparam logic [5:0] CTLS [0:1] = '{6'b111001, 6'b001110};
   logic ref_clk_in = 1'b0, nrst_in = 1'b0, pix_blank_in = 1'b0, pix_valid_in = 1'b0, rdy_s = 1'b0;
   logic dual_edge_in = 1'b0, link_en_in = 1'b0, serial_link_clock_in = 1'b0, lk_run = 1'b1;
   logic [23:0] pix_data_in = 24'h0;
   logic [5:0] pix_ctl_in = 6'h0;
   logic [2:0] fmt_sel_in = 3'h3;
   wire pix_ready_out, panel_shift_clock_out, serial_link_clock_out;
   wire [23:0] panel_data_out, word;
   wire [9:0] serial_lane_0_out, serial_lane_1_out, serial_lane_2_out;
   wire [29:0] sym;
   wire [15:0] pcnt, lcnt;
   int errors = 0, samples_checked = 0, k, m, n, got;
   fpo_top dut (.*);
   fpo_panel_model far (.ref_clk_in(ref_clk_in), .dual_in(dual_edge_in), .shift_in(panel_shift_clock_out),
      .pdata_in(panel_data_out), .lclk_in(serial_link_clock_out),
      .lanes_in({serial_lane_2_out, serial_lane_1_out, serial_lane_0_out}), .word_out(word), .sym_out(sym),
      .pcnt_out(pcnt), .lcnt_out(lcnt));
   initial forever #5 ref_clk_in = ~ref_clk_in;
   // The link clock is offset so its edges never meet the system clock edges.
   initial begin
      #3.3;
      forever #62.5 serial_link_clock_in = lk_run ? ~serial_link_clock_in : 1'b0;
   end
   always @(negedge ref_clk_in) rdy_s = pix_ready_out;
   function automatic logic rsv(input logic [9:0] s);
      rsv = s === `FPO_CTRL_SYM_00 || s === `FPO_CTRL_SYM_01 || s === `FPO_CTRL_SYM_10 || s === `FPO_CTRL_SYM_11;
   endfunction
   function automatic logic [29:0] blank_sym(input logic [5:0] c);
      logic [9:0] rs [0:3] = '{`FPO_CTRL_SYM_00, `FPO_CTRL_SYM_01, `FPO_CTRL_SYM_10, `FPO_CTRL_SYM_11};
      blank_sym = {rs[c[5:4]], rs[c[3:2]], rs[c[1:0]]};
   endfunction
   task automatic chk(input string nm, input logic [29:0] seen, input logic [29:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic give_up;
      errors++;
      conclude;
   endtask
   task automatic push(input logic [23:0] d, input logic [5:0] c, input logic b);
      pix_data_in <= d;
      pix_ctl_in <= c;
      pix_blank_in <= b;
      pix_valid_in <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk_in);
         k++;
      end while (rdy_s !== 1'b1 && k < 200);
      if (k >= 200) give_up;
   endtask
   task automatic wait_cap;
      m = lcnt;
      for (k = 0; k < 100 && lcnt == m; k++) @(posedge ref_clk_in);
      if (k >= 100) give_up;
   endtask
   task automatic link_word(input logic [23:0] d, input logic [5:0] c, input logic b);
      wait_cap;
      push(d, c, b);
      pix_valid_in <= 1'b0;
      wait_cap;
   endtask
   initial begin
      repeat (4) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      foreach (ROWS[i]) begin
         dual_edge_in <= ROWS[i].d;
         fmt_sel_in <= ROWS[i].f;
         @(posedge ref_clk_in);
         n = (ROWS[i].f inside {3'h0, 3'h1, 3'h5}) ? 8 : (ROWS[i].f == 3'h4 ? 2 : 1);
         got = pcnt;
         for (int j = 0; j < n; j++) push(ROWS[i].s[j] ? ROWS[i].p0 : ROWS[i].p1, 6'h0, 1'b0);
         pix_valid_in <= 1'b0;
         for (k = 0; k < 100 && pcnt == got; k++) @(posedge ref_clk_in);
         if (k >= 100) give_up;
         chk("panel_word", {6'h0, word}, {6'h0, ROWS[i].e});
      end
      link_en_in <= 1'b1;
      foreach (CTLS[i]) begin
         link_word(24'h0, CTLS[i], 1'b1);
         chk("blank_sym", sym, blank_sym(CTLS[i]));
      end
      chk("pins_low", {6'h0, panel_data_out}, 30'h0);
      link_word(24'h5a3cc3, 6'h0, 1'b0);
      chk("data_sym", {27'h0, rsv(sym[29:20]), rsv(sym[19:10]), rsv(sym[9:0])}, 30'h0);
      wait_cap;
      chk("held_ctl", sym, blank_sym(CTLS[1]));
      wait_cap;
      lk_run = 1'b0;
      pix_valid_in <= 1'b1;
      n = 0;
      repeat (20) begin
         @(posedge ref_clk_in);
         n += rdy_s;
      end
      pix_valid_in <= 1'b0;
      chk("fifo_full", {29'h0, n inside {16, 17}}, 30'h1);
      lk_run = 1'b1;
      got = 0;
      for (int i = 0; i < 40; i++) begin
         wait_cap;
         if (rsv(sym[9:0])) break;
         got++;
      end
      chk("drained", 30'(got), 30'(n));
      nrst_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      #1;
      chk("reset_lanes", {serial_lane_2_out, serial_lane_1_out, serial_lane_0_out}, {3{`FPO_CTRL_SYM_00}});
      chk("reset_out", {3'h0, pix_ready_out, serial_link_clock_out, panel_shift_clock_out, panel_data_out}, 30'h0);
      @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk("ready_after_reset", {29'h0, pix_ready_out}, 30'h1);
      conclude;
   end
endmodule // flat_panel_pixel_output_tb
